// >>> pkg/gpo_map.vh
// Register offsets, field positions and reset values of the GPIO ports
`ifndef GPO_MAP_VH
`define GPO_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GPO_OFS_PA_IN     8'h00
`define GPO_OFS_PA_DIR    8'h04
`define GPO_OFS_PA_LATCH  8'h08
`define GPO_OFS_PB_IN     8'h0C
`define GPO_OFS_PB_DIR    8'h10
`define GPO_OFS_PB_LATCH  8'h14
`define GPO_OFS_CTRL      8'h18

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define GPO_CTRL_POS_BIT  0
`define GPO_RST_BYTE      8'h00
`define GPO_RST_OE_N      8'hFF
`define GPO_RST_CTRL      1'b0
`define GPO_RST_WORD      32'h00000000

`endif

// >>> verilog/gpo_pin_sync.v
// Two-flop synchroniser for a bus of asynchronous pin levels
`timescale 1ns/1ps
module gpo_pin_sync #(
  parameter WIDTH = 16
) (
  input  wire             clk_sys,
  input  wire             rst_sync_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second; metastability settles there
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// >>> verilog/gpo_pb_override.v
// Alternate-function override logic for port B pins 0 to 3
`timescale 1ns/1ps
module gpo_pb_override (
  input  wire [3:0] latch,
  input  wire [3:0] dir,
  input  wire       pos_sel,
  input  wire       two_wire,
  input  wire       three_wire,
  input  wire       shift_out,
  input  wire       clk_hold,
  input  wire       oc_a,
  input  wire       oc_b,
  input  wire       route_a_u,
  input  wire       route_a_v,
  input  wire       route_b_u,
  input  wire       route_b_v,
  output reg  [3:0] out_val,
  output reg  [3:0] out_dir,
  output wire [3:0] pull_ovr_en,
  output wire [3:0] pull_ovr_val,
  output wire [3:0] analog_en
);

  wire tw_here;
  wire wire_here;
  wire pb0_low;
  wire pb2_low;

  // ----------------------------------------------------------------------
  // Serial interface conditions at this pin position
  // ----------------------------------------------------------------------
  assign tw_here   = two_wire & pos_sel;
  assign wire_here = (two_wire | three_wire) & pos_sel;
  assign pb0_low   = tw_here & dir[0];
  assign pb2_low   = tw_here & dir[2];

  // No pull-up override and no analog path on these pins
  assign pull_ovr_en  = 4'h0;
  assign pull_ovr_val = 4'h0;
  assign analog_en    = 4'h0;

  // Output value: open-drain low (PB1: shifter) first, timer next, latch otherwise
  always @* begin
    out_val = latch;
    if (pb0_low)
      out_val[0] = 1'b0;
    else if (route_a_u)
      out_val[0] = oc_a;
    if (wire_here)
      out_val[1] = shift_out;
    else if (route_b_u)
      out_val[1] = oc_b;
    if (pb2_low)
      out_val[2] = 1'b0;
    else if (route_a_v)
      out_val[2] = oc_a;
    if (route_b_v)
      out_val[3] = oc_b;
  end

  // Direction: two-wire mode lets the serial unit release the line
  always @* begin
    out_dir = dir;
    if (tw_here) begin
      out_dir[0] = (shift_out | latch[0]) & dir[0];
      out_dir[2] = (clk_hold | latch[2]) & dir[2];
    end
  end

endmodule

// >>> verilog/gpo_port_top.v
// GPIO ports A and B with APB registers and port B overrides
//
// Functional notes
// - PB2 drives low in two-wire mode with direction set, else timer A.
// - PB1 drives shifter output in wire mode, else timer compare B.
// - PB0 drives low in two-wire mode with direction set, else timer A.
// - Sampled PB2 feeds pin change, serial clock and two-wire clock.
// - Sampled PB0 feeds pin change, serial data and two-wire data.
// - Pins PB0..PB3 have no pull-up override and no analog path.
// - Port A output latch, 8 bits read/write, resets to zero.
// - Port B output latch, 8 bits read/write, resets to zero.
// - Port A direction, 8 bits read/write, resets to all inputs.
// - Port B direction, 8 bits read/write, resets to zero.
// - Input registers return pin levels; writes toggle latch bits.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "gpo_map.vh"
module gpo_port_top (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [7:0]  pa_in,
  output reg  [7:0]  pa_out,
  output reg  [7:0]  pa_oe_n,
  output reg  [7:0]  pa_pullup,
  input  wire [7:0]  pb_in,
  output reg  [7:0]  pb_out,
  output reg  [7:0]  pb_oe_n,
  output reg  [7:0]  pb_pullup,
  output reg  [3:0]  pb_analog_en,
  input  wire        serial_iface_two_wire_active,
  input  wire        serial_iface_three_wire_active,
  input  wire        serial_shifter_output,
  input  wire        serial_clock_hold,
  input  wire        timer_compare_out_a,
  input  wire        timer_compare_out_b,
  input  wire        timer_route_a_u,
  input  wire        timer_route_a_v,
  input  wire        timer_route_b_u,
  input  wire        timer_route_b_v,
  output wire        serial_iface_pin_position_select,
  output wire        pin_change_input_8,
  output wire        pin_change_input_10,
  output wire        serial_iface_clock_in,
  output wire        serial_iface_data_in,
  output wire        two_wire_clock_in,
  output wire        two_wire_data_in,
  output wire [7:0]  pin_change_a,
  output wire [7:0]  pin_change_b
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // True when the address selects a mapped register
  function mapped;
    input [7:0] addr;
    begin
      case (addr)
        `GPO_OFS_PA_IN, `GPO_OFS_PA_DIR, `GPO_OFS_PA_LATCH,
        `GPO_OFS_PB_IN, `GPO_OFS_PB_DIR, `GPO_OFS_PB_LATCH,
        `GPO_OFS_CTRL: mapped = 1'b1;
        default:       mapped = 1'b0;
      endcase
    end
  endfunction

  // Next latch value: direct write, toggle by input write, or hold
  function [7:0] latch_next;
    input [7:0] cur;
    input       wr_latch;
    input       wr_toggle;
    input [7:0] data;
    begin
      if (wr_latch)
        latch_next = data;
      else if (wr_toggle)
        latch_next = cur ^ data;
      else
        latch_next = cur;
    end
  endfunction

  // Pull-up enable: latch bit set while the pin is an input
  function [7:0] pull_on;
    input [7:0] lat;
    input [7:0] dir;
    begin
      pull_on = lat & ~dir;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  reg        rst_meta_n;
  reg        rst_sync_n;

  // Assert at once, release two edges later to stay clear of recovery
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg  [7:0] port_a_output_latch;
  reg  [7:0] port_a_direction;
  reg  [7:0] port_b_output_latch;
  reg  [7:0] port_b_direction;
  reg        pos_sel;
  wire [7:0] port_a_input_sample;
  wire [7:0] port_b_input_sample;
  wire [15:0] pins_sync;

  // ----------------------------------------------------------------------
  // Pin input synchronisation
  // ----------------------------------------------------------------------
  gpo_pin_sync #(
    .WIDTH (16)
  ) u_sync (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .async_in   ({pb_in, pa_in}),
    .sync_out   (pins_sync)
  );

  // Reset value is zero from the sync flops, not the pin levels
  assign port_a_input_sample = pins_sync[7:0];
  assign port_b_input_sample = pins_sync[15:8];

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  wire       acc_wr;
  wire       acc_hit;
  wire       wr_pa_in;
  wire       wr_pa_dir;
  wire       wr_pa_latch;
  wire       wr_pb_in;
  wire       wr_pb_dir;
  wire       wr_pb_latch;
  wire       wr_ctrl;
  wire [7:0] wbyte;
  reg  [31:0] next_prdata;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign acc_wr  = psel & penable & pwrite;
  assign acc_hit = acc_wr & mapped(paddr);
  assign wbyte   = pwdata[7:0];

  // Write strobes, one per register
  assign wr_pa_in    = acc_hit & (paddr == `GPO_OFS_PA_IN);
  assign wr_pa_dir   = acc_hit & (paddr == `GPO_OFS_PA_DIR);
  assign wr_pa_latch = acc_hit & (paddr == `GPO_OFS_PA_LATCH);
  assign wr_pb_in    = acc_hit & (paddr == `GPO_OFS_PB_IN);
  assign wr_pb_dir   = acc_hit & (paddr == `GPO_OFS_PB_DIR);
  assign wr_pb_latch = acc_hit & (paddr == `GPO_OFS_PB_LATCH);
  assign wr_ctrl     = acc_hit & (paddr == `GPO_OFS_CTRL);

  // Register writes; an input-register write toggles the latch bits
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port_a_output_latch <= `GPO_RST_BYTE;
      port_a_direction    <= `GPO_RST_BYTE;
      port_b_output_latch <= `GPO_RST_BYTE;
      port_b_direction    <= `GPO_RST_BYTE;
      pos_sel             <= `GPO_RST_CTRL;
    end else begin
      port_a_output_latch <= latch_next(port_a_output_latch,
                                        wr_pa_latch, wr_pa_in,
                                        wbyte);
      port_b_output_latch <= latch_next(port_b_output_latch,
                                        wr_pb_latch, wr_pb_in,
                                        wbyte);
      if (wr_pa_dir)
        port_a_direction <= wbyte;
      if (wr_pb_dir)
        port_b_direction <= wbyte;
      if (wr_ctrl)
        pos_sel <= pwdata[`GPO_CTRL_POS_BIT];
    end
  end

  // Read mux; unmapped reads return zero alongside pslverr
  always @* begin
    next_prdata = `GPO_RST_WORD;
    case (paddr)
      `GPO_OFS_PA_IN:    next_prdata[7:0] = port_a_input_sample;
      `GPO_OFS_PA_DIR:   next_prdata[7:0] = port_a_direction;
      `GPO_OFS_PA_LATCH: next_prdata[7:0] = port_a_output_latch;
      `GPO_OFS_PB_IN:    next_prdata[7:0] = port_b_input_sample;
      `GPO_OFS_PB_DIR:   next_prdata[7:0] = port_b_direction;
      `GPO_OFS_PB_LATCH: next_prdata[7:0] = port_b_output_latch;
      `GPO_OFS_CTRL:     next_prdata[`GPO_CTRL_POS_BIT] = pos_sel;
      default:           next_prdata = `GPO_RST_WORD;
    endcase
  end

  // Read data caught in the setup cycle, so it is stable in access
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n)
      prdata <= `GPO_RST_WORD;
    else if (psel & ~penable & ~pwrite)
      prdata <= next_prdata;
  end

  // ----------------------------------------------------------------------
  // Port B alternate functions
  // ----------------------------------------------------------------------
  wire [3:0] ovr_val;
  wire [3:0] ovr_dir;
  wire [3:0] pull_en;
  wire [3:0] pull_val;
  wire [3:0] ana_en;

  gpo_pb_override u_ovr (
    .latch        (port_b_output_latch[3:0]),
    .dir          (port_b_direction[3:0]),
    .pos_sel      (pos_sel),
    .two_wire     (serial_iface_two_wire_active),
    .three_wire   (serial_iface_three_wire_active),
    .shift_out    (serial_shifter_output),
    .clk_hold     (serial_clock_hold),
    .oc_a         (timer_compare_out_a),
    .oc_b         (timer_compare_out_b),
    .route_a_u    (timer_route_a_u),
    .route_a_v    (timer_route_a_v),
    .route_b_u    (timer_route_b_u),
    .route_b_v    (timer_route_b_v),
    .out_val      (ovr_val),
    .out_dir      (ovr_dir),
    .pull_ovr_en  (pull_en),
    .pull_ovr_val (pull_val),
    .analog_en    (ana_en)
  );

  // ----------------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------------
  wire [7:0] pb_dir_eff;
  wire [7:0] pb_pull_base;

  // Low port B pins use the overridden direction; a line that the
  // serial unit releases has its latch bit clear, so its pull-up stays off
  assign pb_dir_eff   = {port_b_direction[7:4], ovr_dir};
  assign pb_pull_base = pull_on(port_b_output_latch, pb_dir_eff);

  // Registered pads; one cycle late but glitch-free at the pin
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pa_out       <= `GPO_RST_BYTE;
      pa_oe_n      <= `GPO_RST_OE_N;
      pa_pullup    <= `GPO_RST_BYTE;
      pb_out       <= `GPO_RST_BYTE;
      pb_oe_n      <= `GPO_RST_OE_N;
      pb_pullup    <= `GPO_RST_BYTE;
      pb_analog_en <= 4'h0;
    end else begin
      pa_out       <= port_a_output_latch;
      pa_oe_n      <= ~port_a_direction;
      pa_pullup    <= pull_on(port_a_output_latch, port_a_direction);
      pb_out       <= {port_b_output_latch[7:4], ovr_val};
      pb_oe_n      <= ~pb_dir_eff;
      pb_pullup[7:4] <= pb_pull_base[7:4];
      // Override enable is zero, so pull-up follows latch and dir
      pb_pullup[3:0] <= (pull_en & pull_val) |
                        (~pull_en & pb_pull_base[3:0]);
      pb_analog_en <= ana_en;
    end
  end

  // ----------------------------------------------------------------------
  // Input routing
  // ----------------------------------------------------------------------
  // Synchronised levels go straight out; no extra flop of delay
  assign serial_iface_pin_position_select = pos_sel;
  assign pin_change_a          = port_a_input_sample;
  assign pin_change_b          = port_b_input_sample;

  // PB2 sample fans out to pin change, serial clock and two-wire clock
  assign pin_change_input_10   = port_b_input_sample[2];
  assign serial_iface_clock_in = port_b_input_sample[2];
  assign two_wire_clock_in     = port_b_input_sample[2];

  // PB0 sample fans out to pin change, serial data and two-wire data
  assign pin_change_input_8    = port_b_input_sample[0];
  assign serial_iface_data_in  = port_b_input_sample[0];
  assign two_wire_data_in      = port_b_input_sample[0];

endmodule

// >>> tb/gpo_pin_model.sv
// Pad model: each pin shows the port drive or the outside driver
`timescale 1ns/1ps
module gpo_pin_model (
  input  wire [7:0] out_v,
  input  wire [7:0] oe_n,
  input  wire [7:0] ext_v,
  output wire [7:0] pin_v
);
  // Released pads follow the outside driver, never a stale port value
  assign pin_v = (~oe_n & out_v) | (oe_n & ext_v);
endmodule

// >>> tb/gpo_port_props.sv
// Checker for the GPIO port block, bound to its top module
`timescale 1ns/1ps
module gpo_port_props (
  input wire       clk_sys,
  input wire       rst_n,
  input wire [7:0] pb_in,
  input wire [7:0] pb_out,
  input wire [7:0] pb_oe_n,
  input wire [3:0] pb_analog_en,
  input wire       serial_iface_two_wire_active,
  input wire       serial_iface_three_wire_active,
  input wire       serial_shifter_output,
  input wire       timer_compare_out_a,
  input wire       timer_compare_out_b,
  input wire       timer_route_a_u,
  input wire       timer_route_a_v,
  input wire       timer_route_b_u,
  input wire       serial_iface_pin_position_select,
  input wire       pin_change_input_8,
  input wire       pin_change_input_10,
  input wire       serial_iface_clock_in,
  input wire       serial_iface_data_in,
  input wire       two_wire_clock_in,
  input wire       two_wire_data_in,
  input wire [7:0] pin_change_b
);
  reg  [2:0] age;
  wire       ok;
  wire       tw;
  wire       wm;
  // Sync flops stay cleared a few edges after reset lets go
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  // Two-wire and any-wire serial modes at this pin position
  assign ok = (age == 3'h7);
  assign tw = serial_iface_two_wire_active & serial_iface_pin_position_select;
  assign wm = tw | (serial_iface_three_wire_active &
                    serial_iface_pin_position_select);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence pins_quiet;
    ok && $stable(pb_in) ##1 $stable(pb_in);
  endsequence
  analog_off_a: assert property (pb_analog_en == 4'h0)
    else $error("analog path enabled");
  pb2_low_a: assert property
    (ok && $past(tw) && !pb_oe_n[2] |-> !pb_out[2])
    else $error("pb2 not low in two-wire mode");
  pb2_timer_a: assert property
    (ok && $past(!tw && timer_route_a_v) |->
     pb_out[2] == $past(timer_compare_out_a))
    else $error("pb2 not following timer a");
  pb0_low_a: assert property
    (ok && $past(tw) && !pb_oe_n[0] |-> !pb_out[0])
    else $error("pb0 not low in two-wire mode");
  pb0_timer_a: assert property
    (ok && $past(!tw && timer_route_a_u) |->
     pb_out[0] == $past(timer_compare_out_a))
    else $error("pb0 not following timer a");
  pb1_shift_a: assert property
    (ok && $past(wm) |-> pb_out[1] == $past(serial_shifter_output))
    else $error("pb1 not following shifter");
  pb1_timer_a: assert property
    (ok && $past(!wm && timer_route_b_u) |->
     pb_out[1] == $past(timer_compare_out_b))
    else $error("pb1 not following timer b");
  clk_route_a: assert property
    (ok |-> pin_change_input_10 == $past(pb_in[2], 2) &&
     serial_iface_clock_in == $past(pb_in[2], 2) &&
     two_wire_clock_in == $past(pb_in[2], 2))
    else $error("pb2 input routes differ");
  data_route_a: assert property
    (ok |-> pin_change_input_8 == $past(pb_in[0], 2) &&
     serial_iface_data_in == $past(pb_in[0], 2) &&
     two_wire_data_in == $past(pb_in[0], 2))
    else $error("pb0 input routes differ");
  sync_delay_a: assert property
    (pins_quiet |-> pin_change_b == $past(pb_in, 2))
    else $error("sampled pins lag wrong");
endmodule
bind gpo_port_top gpo_port_props u_props (
  .clk_sys, .rst_n, .pb_in, .pb_out, .pb_oe_n, .pb_analog_en,
  .serial_iface_two_wire_active, .serial_iface_three_wire_active,
  .serial_shifter_output, .timer_compare_out_a, .timer_compare_out_b,
  .timer_route_a_u, .timer_route_a_v, .timer_route_b_u,
  .serial_iface_pin_position_select, .pin_change_input_8,
  .pin_change_input_10, .serial_iface_clock_in, .serial_iface_data_in,
  .two_wire_clock_in, .two_wire_data_in, .pin_change_b
);

// >>> tb/gpo_port_top_tb.sv
// Self-checking bench for the GPIO port block
`timescale 1ns/1ps
`include "gpo_map.vh"
module gpo_port_top_tb;
  reg         clk_sys, rst_n, psel, penable, pwrite, err;
  reg   [7:0] paddr, ext_a, ext_b, a;
  reg  [31:0] pwdata, rd;
  reg   [9:0] per;
  wire [31:0] prdata;
  wire        pready, pslverr;
  wire  [7:0] pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n, pb_pullup;
  wire  [7:0] pin_change_a, pin_change_b, pa_pullup;
  wire        pos_sel_out;
  wire  [3:0] pb_analog_en;
  wire        pin_change_input_8, serial_iface_data_in, two_wire_data_in;
  wire        pin_change_input_10, serial_iface_clock_in, two_wire_clock_in;
  integer     n_errors, check_count, i;

  gpo_port_top u_dut (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pa_in, .pa_out, .pa_oe_n, .pa_pullup,
    .pb_in, .pb_out, .pb_oe_n, .pb_pullup, .pb_analog_en,
    .serial_iface_two_wire_active(per[9]),
    .serial_iface_three_wire_active(per[8]),
    .serial_shifter_output(per[7]),
    .serial_clock_hold(per[6]),
    .timer_compare_out_a(per[5]),
    .timer_compare_out_b(per[4]),
    .timer_route_a_u(per[3]),
    .timer_route_a_v(per[2]),
    .timer_route_b_u(per[1]),
    .timer_route_b_v(per[0]),
    .serial_iface_pin_position_select(pos_sel_out), .pin_change_input_8,
    .pin_change_input_10, .serial_iface_clock_in, .serial_iface_data_in,
    .two_wire_clock_in, .two_wire_data_in, .pin_change_a, .pin_change_b
  );
  gpo_pin_model u_pa (.out_v(pa_out), .oe_n(pa_oe_n), .ext_v(ext_a),
                      .pin_v(pa_in));
  gpo_pin_model u_pb (.out_v(pb_out), .oe_n(pb_oe_n), .ext_v(ext_b),
                      .pin_v(pb_in));

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  // ------------------------------
  // Tasks
  // ------------------------------
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // One transfer; request held until pready is seen high
  task apb(input w, input [7:0] ad, input [31:0] d);
    integer k;
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && k < 16) begin
        k = k + 1;
        @(posedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 16) begin
        n_errors = n_errors + 1;
        give_verdict;
      end
    end
  endtask
  task rdchk(input [7:0] ad, input [7:0] exp);
    begin
      apb(1'b0, ad, 32'h00000000);
      chk("prdata", rd, {24'h000000, exp});
    end
  endtask
  // Pads need one edge, the pin sync two more
  task settle;
    begin
      repeat (4) @(posedge clk_sys);
      #1;
    end
  endtask
  task drive(input [9:0] v, input [7:0] xa, input [7:0] xb);
    begin
      @(posedge clk_sys);
      per <= v;
      ext_a <= xa;
      ext_b <= xb;
      settle;
    end
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    {per, ext_a, ext_b} = 26'h0;
    n_errors = 0;
    check_count = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (a = 8'h04; a != 8'h1C; a = a + 8'h04) begin
      if (a != 8'h0C) rdchk(a, 8'h00);
    end
    // Upper data bits set on purpose; they must read back zero
    for (a = 8'h04; a != 8'h18; a = a + 8'h04) begin
      if (a != 8'h0C) begin
        apb(1'b1, a, {24'hFFFFFF, a ^ 8'hA5});
        rdchk(a, a ^ 8'hA5);
      end
    end
    apb(1'b1, 8'h1C, 32'h000000FF);
    rdchk(8'h1C, 8'h00);
    chk("pslverr", err, 1);
    drive(10'h000, 8'h3C, 8'h00);
    chk("pa_oe_n", pa_oe_n, 8'h5E);
    chk("pa_out", pa_out, 8'hAD);
    chk("pa_pullup", pa_pullup, 8'h0C);
    chk("pin_change_a", pin_change_a, 8'hBD);
    rdchk(`GPO_OFS_PA_IN, 8'hBD);
    apb(1'b1, `GPO_OFS_PA_IN, 32'h0000000F);
    rdchk(`GPO_OFS_PA_LATCH, 8'hA2);
    // Timer compare outputs routed to PB0..PB3
    for (i = 0; i < 2; i = i + 1) begin
      drive({4'h0, i[0], i[0], 4'hF}, 8'h3C, 8'h00);
      chk("pb_out", pb_out[3:0], {4{i[0]}});
    end
    apb(1'b1, `GPO_OFS_CTRL, 32'h00000001);
    rdchk(`GPO_OFS_CTRL, 8'h01);
    chk("pos_sel", pos_sel_out, 1);
    drive(10'b1010101110, 8'h3C, 8'h00);
    chk("pb_out", pb_out[2:0], 3'b010);
    chk("pb_oe_n2", pb_oe_n[2], 1);
    drive(10'b1011101110, 8'h3C, 8'h00);
    chk("pb_oe_n2", pb_oe_n[2], 0);
    drive(10'b0100101110, 8'h3C, 8'h00);
    chk("pb_out", pb_out[2:0], 3'b101);
    // Released port B pins feed every routed input
    apb(1'b1, `GPO_OFS_PB_DIR, 32'h00000000);
    for (i = 0; i < 2; i = i + 1) begin
      a = i[0] ? 8'hFA : 8'h05;
      drive(10'h000, 8'h3C, a);
      chk("pb2 routes", {pin_change_input_10, serial_iface_clock_in,
          two_wire_clock_in}, {3{a[2]}});
      chk("pb0 routes", {pin_change_input_8, serial_iface_data_in,
          two_wire_data_in}, {3{a[0]}});
      rdchk(`GPO_OFS_PB_IN, a);
    end
    chk("pb_pullup", pb_pullup, 8'hB1);
    chk("pb_analog_en", pb_analog_en, 4'h0);
    give_verdict;
  end
endmodule
